// ==== verilog/erp_top.v ====
// Purpose: Region pointer registers four and three with region lookup
// Assumes: Pointers two to zero come from same-clock logic
// Notes: Writes only program ones to zeros; erase restores factory
`timescale 1ns/100ps
`include "erp_defs.vh"

module erp_top #(
	parameter DEFAULT_TYPE = 1'b1
) (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire [`ERP_ADDR_W-1:0] reg_addr_i,
	input wire [`ERP_DATA_W-1:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [`ERP_DATA_W-1:0] reg_rdata_o,
	input wire [`ERP_PTR_W-1:0] ptr2_word_i,
	input wire [`ERP_PTR_W-1:0] ptr1_word_i,
	input wire [`ERP_PTR_W-1:0] ptr0_word_i,
	input wire [`ERP_SEC_W-1:0] core_sector_i,
	output reg core_hit_o,
	output reg core_type_o,
	output reg [`ERP_IDX_W-1:0] core_idx_o,
	output reg [`ERP_SEC_W-1:0] ptr4_start_sector_o,
	output reg ptr4_region_type_o,
	output reg ptr4_enable_bit_o,
	output reg [`ERP_SEC_W-1:0] ptr3_start_sector_o,
	output reg ptr3_region_type_o,
	output reg ptr3_enable_bit_o
);

	// Stored pointer words
	reg [`ERP_PTR_W-1:0] region_pointer_four_q;
	reg [`ERP_PTR_W-1:0] region_pointer_four_d;
	reg [`ERP_PTR_W-1:0] region_pointer_three_q;
	reg [`ERP_PTR_W-1:0] region_pointer_three_d;

	// Control and status
	reg lock_q;
	reg lock_d;
	reg fail_q;
	reg fail_d;
	reg [`ERP_SEC_W-1:0] query_q;
	reg [`ERP_SEC_W-1:0] query_d;

	wire [`ERP_PTR_W-1:0] wdata_ptr;
	wire wr_ptr4;
	wire wr_ptr3;
	wire wr_ctrl;
	wire wr_query;
	wire erase_req;
	wire clrfail_req;
	wire bad_prog4;
	wire bad_prog3;
	wire locked_hit;
	wire fail_set;

	wire [`ERP_NPTR*`ERP_PTR_W-1:0] ptr_bus;
	wire q_hit;
	wire q_type;
	wire [`ERP_IDX_W-1:0] q_idx;
	wire c_hit;
	wire c_type;
	wire [`ERP_IDX_W-1:0] c_idx;

	reg [`ERP_DATA_W-1:0] rdata_d;

	function bit_raise;
		input [`ERP_PTR_W-1:0] old_w;
		input [`ERP_PTR_W-1:0] new_w;
		begin
			bit_raise = |(new_w & ~old_w);
		end
	endfunction

	// Register port decode
	assign wdata_ptr = reg_wdata_i[`ERP_PTR_W-1:0];
	assign wr_ptr4 = reg_wr_i && (reg_addr_i == `ERP_OFF_PTR4);
	assign wr_ptr3 = reg_wr_i && (reg_addr_i == `ERP_OFF_PTR3);
	assign wr_ctrl = reg_wr_i && (reg_addr_i == `ERP_OFF_CTRL);
	assign wr_query = reg_wr_i && (reg_addr_i == `ERP_OFF_QUERY);
	assign erase_req = wr_ctrl && reg_wdata_i[`ERP_CTRL_ERASE];
	assign clrfail_req = wr_ctrl && reg_wdata_i[`ERP_CTRL_CLRFAIL];

	// Nonvolatile cells can only be programmed towards zero
	assign bad_prog4 = wr_ptr4 && bit_raise(region_pointer_four_q, wdata_ptr);
	assign bad_prog3 = wr_ptr3 && bit_raise(region_pointer_three_q, wdata_ptr);
	assign locked_hit = lock_q && (wr_ptr4 || wr_ptr3 || erase_req);
	assign fail_set = bad_prog4 || bad_prog3 || locked_hit;

	// Pointer word update
	always @* begin
		region_pointer_four_d = region_pointer_four_q;
		region_pointer_three_d = region_pointer_three_q;
		if (!lock_q) begin
			if (erase_req) begin
				region_pointer_four_d = `ERP_PTR_FACTORY; // see RULE_02
				region_pointer_three_d = `ERP_PTR_FACTORY; // see RULE_03
			end else if (wr_ptr4) begin
				region_pointer_four_d = region_pointer_four_q & wdata_ptr; // see RULE_02
			end else if (wr_ptr3) begin
				region_pointer_three_d = region_pointer_three_q & wdata_ptr; // see RULE_03
			end
		end
	end

	// Control, fail flag and query sector
	always @* begin
		lock_d = lock_q;
		fail_d = fail_q;
		query_d = query_q;
		if (wr_ctrl && reg_wdata_i[`ERP_CTRL_LOCK]) begin
			lock_d = 1'b1;
		end
		if (fail_set) begin
			fail_d = 1'b1;
		end else if (clrfail_req) begin
			fail_d = 1'b0;
		end
		if (wr_query) begin
			query_d = reg_wdata_i[`ERP_SEC_W-1:0];
		end
	end

	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			region_pointer_four_q <= `ERP_PTR_FACTORY; // see RULE_04
			region_pointer_three_q <= `ERP_PTR_FACTORY; // see RULE_05
			lock_q <= 1'b0;
			fail_q <= 1'b0;
			query_q <= `ERP_QUERY_RESET;
		end else begin
			region_pointer_four_q <= region_pointer_four_d;
			region_pointer_three_q <= region_pointer_three_d;
			lock_q <= lock_d;
			fail_q <= fail_d;
			query_q <= query_d;
		end
	end

	// All five pointers feed the lookups, pointer 0 lowest
	assign ptr_bus = {region_pointer_four_q, region_pointer_three_q,
		ptr2_word_i, ptr1_word_i, ptr0_word_i}; // see RULE_01

	erp_region_lookup #(
		.DEFAULT_TYPE(DEFAULT_TYPE)
	) u_query_lookup (
		.ptrs_i(ptr_bus),
		.sector_i(query_q),
		.hit_o(q_hit),
		.type_o(q_type),
		.idx_o(q_idx)
	);

	erp_region_lookup #(
		.DEFAULT_TYPE(DEFAULT_TYPE)
	) u_core_lookup (
		.ptrs_i(ptr_bus),
		.sector_i(core_sector_i),
		.hit_o(c_hit),
		.type_o(c_type),
		.idx_o(c_idx)
	);

	// Read mux, unmapped reads return zero
	always @* begin
		rdata_d = `ERP_DATA_ZERO;
		case (reg_addr_i)
			`ERP_OFF_PTR4: begin
				rdata_d[`ERP_PTR_W-1:0] = region_pointer_four_q;
			end
			`ERP_OFF_PTR3: begin
				rdata_d[`ERP_PTR_W-1:0] = region_pointer_three_q;
			end
			`ERP_OFF_CTRL: begin
				rdata_d[`ERP_CTRL_LOCK] = lock_q;
			end
			`ERP_OFF_STAT: begin
				rdata_d[`ERP_STAT_FAIL] = fail_q;
				rdata_d[`ERP_STAT_LOCK] = lock_q;
				rdata_d[`ERP_STAT_HIT] = q_hit;
				rdata_d[`ERP_STAT_TYPE] = q_type; // see RULE_08
				rdata_d[`ERP_STAT_IDX_MSB:`ERP_STAT_IDX_LSB] = q_idx;
			end
			`ERP_OFF_QUERY: begin
				rdata_d[`ERP_SEC_W-1:0] = query_q;
			end
			default: begin
				rdata_d = `ERP_DATA_ZERO;
			end
		endcase
	end

	// Registered outputs
	always @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			reg_rdata_o <= `ERP_DATA_ZERO;
			core_hit_o <= 1'b0;
			core_type_o <= DEFAULT_TYPE;
			core_idx_o <= `ERP_IDX_NONE;
			ptr4_start_sector_o <= {`ERP_SEC_W{1'b1}};
			ptr4_region_type_o <= 1'b1;
			ptr4_enable_bit_o <= 1'b0;
			ptr3_start_sector_o <= {`ERP_SEC_W{1'b1}};
			ptr3_region_type_o <= 1'b1;
			ptr3_enable_bit_o <= 1'b0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rdata_d : `ERP_DATA_ZERO;
			core_hit_o <= c_hit; // see RULE_08
			core_type_o <= c_type;
			core_idx_o <= c_idx;
			ptr4_start_sector_o <= region_pointer_four_q[`ERP_SEC_MSB:`ERP_SEC_LSB]; // see RULE_02
			ptr4_region_type_o <= region_pointer_four_q[`ERP_TYPE_BIT]; // see RULE_04
			ptr4_enable_bit_o <= ~region_pointer_four_q[`ERP_DIS_BIT]; // see RULE_06
			ptr3_start_sector_o <= region_pointer_three_q[`ERP_SEC_MSB:`ERP_SEC_LSB]; // see RULE_03
			ptr3_region_type_o <= region_pointer_three_q[`ERP_TYPE_BIT]; // see RULE_05
			ptr3_enable_bit_o <= ~region_pointer_three_q[`ERP_DIS_BIT]; // see RULE_07
		end
	end

endmodule

// ==== verilog/erp_defs.vh ====
// Purpose: Constants for the region pointer register bank
// Assumes: Plain register port, 40 MHz clk_sys_i, 16-bit data
// Notes: Offsets are word indices on the register port
// Behaviour
// RULE_01 - Pointers split array into retention/endurance regions
// RULE_02 - Pointer four bits 10:2 start sector, ones
// RULE_03 - Pointer three bits 10:2 start sector, ones
// RULE_04 - Pointer four bit 1 region type, default 1
// RULE_05 - Pointer three bit 1 region type, default 1
// RULE_06 - Pointer four bit 0 low enable, default off
// RULE_07 - Pointer three bit 0 low enable, default off
// RULE_08 - Enabled pointer type spans to next pointer
`ifndef ERP_DEFS_VH
`define ERP_DEFS_VH

`define ERP_ADDR_W 4
`define ERP_DATA_W 16
`define ERP_PTR_W 11
`define ERP_SEC_W 9
`define ERP_IDX_W 3
`define ERP_NPTR 5

`define ERP_OFF_PTR4 4'h0
`define ERP_OFF_PTR3 4'h1
`define ERP_OFF_CTRL 4'h2
`define ERP_OFF_STAT 4'h3
`define ERP_OFF_QUERY 4'h4

`define ERP_SEC_MSB 10
`define ERP_SEC_LSB 2
`define ERP_TYPE_BIT 1
`define ERP_DIS_BIT 0

`define ERP_PTR_FACTORY 11'h7FF
`define ERP_QUERY_RESET 9'h000
`define ERP_DATA_ZERO 16'h0000

`define ERP_CTRL_ERASE 0
`define ERP_CTRL_LOCK 1
`define ERP_CTRL_CLRFAIL 2

`define ERP_STAT_FAIL 0
`define ERP_STAT_LOCK 1
`define ERP_STAT_HIT 2
`define ERP_STAT_TYPE 3
`define ERP_STAT_IDX_LSB 4
`define ERP_STAT_IDX_MSB 6

`define ERP_IDX_NONE 3'h7

`endif

// ==== verilog/erp_region_lookup.v ====
// Purpose: Finds the region that governs one sector
// Assumes: Pointer words packed pointer 0 in the low bits
// Notes: Purely combinational; ties go to the higher pointer
`timescale 1ns/100ps
`include "erp_defs.vh"

module erp_region_lookup #(
	parameter DEFAULT_TYPE = 1'b1
) (
	input wire [`ERP_NPTR*`ERP_PTR_W-1:0] ptrs_i,
	input wire [`ERP_SEC_W-1:0] sector_i,
	output reg hit_o,
	output reg type_o,
	output reg [`ERP_IDX_W-1:0] idx_o
);

	function ptr_enabled;
		input [`ERP_PTR_W-1:0] w;
		begin
			ptr_enabled = ~w[`ERP_DIS_BIT]; // see RULE_06
		end
	endfunction

	function [`ERP_SEC_W-1:0] ptr_start;
		input [`ERP_PTR_W-1:0] w;
		begin
			ptr_start = w[`ERP_SEC_MSB:`ERP_SEC_LSB];
		end
	endfunction

	integer i;
	reg [`ERP_PTR_W-1:0] w;
	reg [`ERP_SEC_W-1:0] best;

	// Nearest enabled start at or below the sector wins
	always @* begin
		hit_o = 1'b0;
		type_o = DEFAULT_TYPE;
		idx_o = `ERP_IDX_NONE;
		best = {`ERP_SEC_W{1'b0}};
		w = {`ERP_PTR_W{1'b0}};
		for (i = 0; i < `ERP_NPTR; i = i + 1) begin
			w = ptrs_i[i*`ERP_PTR_W +: `ERP_PTR_W];
			if (ptr_enabled(w) && ptr_start(w) <= sector_i &&
				(!hit_o || ptr_start(w) >= best)) begin // see RULE_08
				hit_o = 1'b1;
				best = ptr_start(w);
				type_o = w[`ERP_TYPE_BIT]; // see RULE_04
				idx_o = i[`ERP_IDX_W-1:0];
			end
		end
	end

endmodule

// ==== sim/erp_top_properties.sv ====
// Purpose: Port-level checks for the region pointer bank
// Assumes: Decode outputs lag the pointer registers by one cycle
// Notes: Ties at equal start go to pointer four
`timescale 1ns/100ps
`include "erp_defs.vh"
module erp_chk (
	input wire clk_sys_i,
	input wire resetn_i,
	input wire [3:0] reg_addr_i,
	input wire [15:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire [8:0] core_sector_i,
	input wire core_hit_o,
	input wire core_type_o,
	input wire [2:0] core_idx_o,
	input wire [8:0] ptr4_start_sector_o,
	input wire ptr4_region_type_o,
	input wire ptr4_enable_bit_o,
	input wire [8:0] ptr3_start_sector_o,
	input wire ptr3_region_type_o,
	input wire ptr3_enable_bit_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (!resetn_i);
property p_rst4;
	$rose(resetn_i) |-> ptr4_start_sector_o == 9'h1FF && ptr4_region_type_o && !ptr4_enable_bit_o;
endproperty
a_rst4: assert property (p_rst4) else $error("pointer four not factory");
property p_rst3;
	$rose(resetn_i) |-> ptr3_start_sector_o == 9'h1FF && ptr3_region_type_o && !ptr3_enable_bit_o;
endproperty
a_rst3: assert property (p_rst3) else $error("pointer three not factory");
property p_rd4;
	reg_rd_i && reg_addr_i == `ERP_OFF_PTR4 |=>
	reg_rdata_o == {5'h00, ptr4_start_sector_o, ptr4_region_type_o, ~ptr4_enable_bit_o};
endproperty
a_rd4: assert property (p_rd4) else $error("pointer four read layout");
property p_rd3;
	reg_rd_i && reg_addr_i == `ERP_OFF_PTR3 |=>
	reg_rdata_o == {5'h00, ptr3_start_sector_o, ptr3_region_type_o, ~ptr3_enable_bit_o};
endproperty
a_rd3: assert property (p_rd3) else $error("pointer three read layout");
property p_en4;
	$rose(ptr4_enable_bit_o) |-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == `ERP_OFF_PTR4
	&& !$past(reg_wdata_i[0], 2);
endproperty
a_en4: assert property (p_en4) else $error("pointer four enabled unasked");
property p_ty4;
	$fell(ptr4_region_type_o) |-> $past(reg_wr_i, 2) && !$past(reg_wdata_i[1], 2);
endproperty
a_ty4: assert property (p_ty4) else $error("pointer four type dropped");
property p_nohit;
	!core_hit_o |-> core_idx_o == `ERP_IDX_NONE && core_type_o;
endproperty
a_nohit: assert property (p_nohit) else $error("uncovered sector result");
property p_hit4;
	ptr4_enable_bit_o && core_sector_i == ptr4_start_sector_o && !reg_wr_i && !$past(reg_wr_i)
	##1 $stable(core_sector_i)
	|=> core_hit_o && core_idx_o == 3'h4 && core_type_o == $past(ptr4_region_type_o, 2);
endproperty
a_hit4: assert property (p_hit4) else $error("pointer four start not governed");
c_rd4: cover property (reg_rd_i && reg_addr_i == `ERP_OFF_PTR4);
c_hit4: cover property (core_hit_o && core_idx_o == 3'h4);
c_en4: cover property ($rose(ptr4_enable_bit_o));
endmodule
bind erp_top erp_chk i_erp_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .core_sector_i(core_sector_i), .core_hit_o(core_hit_o),
	.core_type_o(core_type_o), .core_idx_o(core_idx_o), .ptr4_start_sector_o(ptr4_start_sector_o),
	.ptr4_region_type_o(ptr4_region_type_o), .ptr4_enable_bit_o(ptr4_enable_bit_o),
	.ptr3_start_sector_o(ptr3_start_sector_o), .ptr3_region_type_o(ptr3_region_type_o),
	.ptr3_enable_bit_o(ptr3_enable_bit_o));

// ==== sim/erp_host.sv ====
// Purpose: Host side of the register port
// Assumes: Read data stands only in the cycle after the strobe
// Notes: Write data scrambled once released
`timescale 1ns/100ps
module erp_host (
	input wire clk_sys_i,
	input wire [15:0] rdata_i,
	output reg [3:0] addr_o,
	output reg [15:0] wdata_o,
	output reg wr_o,
	output reg rd_o
);
initial begin
	addr_o = 4'h0;
	wdata_o = 16'h0000;
	wr_o = 1'b0;
	rd_o = 1'b0;
end
task wr(input [3:0] a, input [15:0] d);
	begin
		@(posedge clk_sys_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_sys_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	end
endtask
task rd(input [3:0] a, output [15:0] d);
	begin
		@(posedge clk_sys_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_sys_i);
		rd_o <= 1'b0;
		@(posedge clk_sys_i);
		d = rdata_i;
	end
endtask
endmodule

// ==== sim/tb_erp_top.sv ====
// Purpose: Self-checking bench for the region pointer bank
// Assumes: Host model drives the register port
// Notes: Pointers two to zero and query sector are random
`timescale 1ns/100ps
`include "erp_defs.vh"
module tb_erp_top;
reg clk_sys_i, resetn_i, lk, fl;
reg [8:0] core_sector_i, qs;
reg [10:0] p [0:4];
reg [15:0] d;
reg [3:0] a;
wire [3:0] a_w;
wire [15:0] d_w, rdata;
wire wr_w, rd_w, hit, ty, t4, e4, t3, e3;
wire [2:0] idx;
wire [8:0] s4, s3;
integer fail_count, checked, seed, i, j;
erp_top i_erp_top (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .reg_addr_i(a_w),
	.reg_wdata_i(d_w), .reg_wr_i(wr_w), .reg_rd_i(rd_w), .reg_rdata_o(rdata), .ptr2_word_i(p[2]),
	.ptr1_word_i(p[1]), .ptr0_word_i(p[0]), .core_sector_i(core_sector_i), .core_hit_o(hit),
	.core_type_o(ty), .core_idx_o(idx), .ptr4_start_sector_o(s4), .ptr4_region_type_o(t4),
	.ptr4_enable_bit_o(e4), .ptr3_start_sector_o(s3), .ptr3_region_type_o(t3),
	.ptr3_enable_bit_o(e3));
erp_host i_erp_host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .addr_o(a_w), .wdata_o(d_w),
	.wr_o(wr_w), .rd_o(rd_w));
initial begin
	clk_sys_i = 1'b0;
	forever #12.5 clk_sys_i = ~clk_sys_i;
end
// Result as {pointer number, type, hit}
function [4:0] look(input [8:0] s);
	integer k;
	reg [8:0] bs;
	begin
		look = 5'h1E;
		bs = 9'h000;
		for (k = 0; k < 5; k = k + 1) begin
			if (!p[k][0] && p[k][10:2] <= s && (!look[0] || p[k][10:2] >= bs)) begin
				bs = p[k][10:2];
				look = {k[2:0], p[k][1], 1'b1};
			end
		end
	end
endfunction
function [15:0] mr(input [3:0] ad);
	case (ad)
		4'h0: mr = {5'h00, p[4]};
		4'h1: mr = {5'h00, p[3]};
		4'h2: mr = {14'h0000, lk, 1'b0};
		4'h3: mr = {9'h000, look(qs), lk, fl};
		4'h4: mr = {7'h00, qs};
		default: mr = 16'h0000;
	endcase
endfunction
task chk(input [15:0] g, input [15:0] e);
	begin
		checked = checked + 1;
		if (g !== e) begin
			fail_count = fail_count + 1;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	end
endtask
task rc(input [3:0] ad);
	reg [15:0] g;
	begin
		i_erp_host.rd(ad, g);
		chk(g, mr(ad));
	end
endtask
task wm(input [3:0] ad, input [15:0] wd);
	begin
		i_erp_host.wr(ad, wd);
		case (ad)
			4'h0, 4'h1: if (lk) fl = 1'b1;
			else begin
				if (|(~p[4 - ad] & wd[10:0])) fl = 1'b1;
				p[4 - ad] = p[4 - ad] & wd[10:0];
			end
			4'h2: begin
				if (wd[2]) fl = 1'b0;
				if (wd[0] && lk) fl = 1'b1;
				if (wd[0] && !lk) begin
					p[3] = 11'h7FF;
					p[4] = 11'h7FF;
				end
				if (wd[1]) lk = 1'b1;
			end
			4'h4: qs = wd[8:0];
			default: ;
		endcase
	end
endtask
task rst;
	begin
		resetn_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		p[3] = 11'h7FF;
		p[4] = 11'h7FF;
		{lk, fl, qs} = 11'h000;
		for (j = 0; j < 6; j = j + 1) rc(j);
	end
endtask
task end_sim;
	begin
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	end
endtask
initial begin
	{fail_count, checked, seed} = {32'd0, 32'd0, 32'd18755};
	resetn_i = 1'b0;
	core_sector_i = 9'h000;
	{p[0], p[1], p[2]} = {3{11'h7FF}};
	rst;
	$display("reset test done");
	for (i = 0; i < 60; i = i + 1) begin
		a = {$random(seed)} % 6;
		d = $random(seed);
		if (a < 2) d = (d | $random(seed)) & 16'h07FF;
		if (a == 2) d[1] = 1'b0;
		wm(a, d);
		j = {$random(seed)} % 6;
		rc(j);
		@(posedge clk_sys_i);
		p[0] <= $random(seed);
		p[1] <= $random(seed);
		p[2] <= $random(seed);
		core_sector_i <= i[0] ? p[4][10:2] : $random(seed);
		repeat (2) @(posedge clk_sys_i);
		#1 chk({11'h000, idx, ty, hit}, {11'h000, look(core_sector_i)});
		chk({5'h00, s4, t4, ~e4}, {5'h00, p[4]});
		chk({5'h00, s3, t3, ~e3}, {5'h00, p[3]});
	end
	$display("random test done");
	wm(4'h2, 16'h0002);
	rc(4'h2);
	wm(4'h0, 16'h0000);
	wm(4'h2, 16'h0001);
	rc(4'h0);
	rc(4'h3);
	wm(4'h2, 16'h0004);
	rc(4'h3);
	$display("lock test done");
	rst;
	$display("second reset test done");
	end_sim;
end
initial begin
	#2000000;
	fail_count = fail_count + 1;
	end_sim;
end
endmodule
